// ===== tb/realtime_pattern_output_port_test.sv
// Self-checking bench of the pattern output unit
`timescale 1ns/10ps
`default_nettype none
module realtime_pattern_output_port_test;
    logic aclk = '0, aresetn = '0, awvalid = '0, wvalid = '0, bready = '0;
    logic arvalid = '0, rready = '0, start_pin_a = '0, start_pin_b = '0;
    logic external_trigger_input = '0, awready, wready, bvalid, arready, rvalid;
    logic [7:0] awaddr = '0, araddr = '0;
    logic [7:0] pattern_output_port_a, pattern_output_port_b;
    logic [31:0] wdata = '0, rdata, got;
    logic [3:0] wstrb = 4'hf;
    logic [1:0] bresp, rresp, resp;
    int failures = 0, comparisons = 0;
    realtime_pattern_output_port dut (.*);
    initial forever #50 aclk = ~aclk;
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            failures++;
            $display("BAD at %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= '1;
        wvalid <= '1;
        bready <= '1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= '0;
            if (wready) wvalid <= '0;
        end while (!bvalid);
        resp = bresp;
        bready <= '0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= '1;
        rready <= '1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= '0;
        end while (!rvalid);
        got = rdata;
        resp = rresp;
        rready <= '0;
    endtask
    // Waits for the pins of set A or B to change, then judges the pattern
    task automatic np(input logic [7:0] e, input bit b = 1'b0);
        logic [7:0] p;
        p = b ? pattern_output_port_b : pattern_output_port_a;
        for (int i = 0; i < 100
             && (b ? pattern_output_port_b : pattern_output_port_a) === p;
             i++)
            @(posedge aclk);
        chk(b ? pattern_output_port_b : pattern_output_port_a, e);
    endtask
    task automatic report_and_stop;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic t_regs;
        rd(rtp_pkg::OFF_CTRL);
        chk(got, 32'h0000_0012);
        wr(8'h3c, '0);
        chk(resp, rtp_pkg::RESP_SLVERR);
        rd(8'h3c);
        chk(resp, rtp_pkg::RESP_SLVERR);
        wr(rtp_pkg::OFF_PTR[0], 32'h0000_0007);
        for (int k = 7; k >= 0; k--)
            wr(rtp_pkg::OFF_PAT, 32'h0000_00a0 + k);
        for (int i = 3; i > 1; i--) begin
            wr(rtp_pkg::OFF_LAT_LO[0], i);
            wr(rtp_pkg::OFF_LAT_HI[0], '0);
        end
        rd(rtp_pkg::OFF_WPTR);
        chk(got, 32'h0000_0003);
        rd(rtp_pkg::OFF_PAT);
        chk(got, 32'h0000_00a7);
        $display("register test done");
    endtask
    task automatic t_repeat;
        logic [7:0] seq [8] = '{5, 4, 3, 2, 1, 0, 7, 6};
        wr(rtp_pkg::OFF_PTR[0], 32'h0000_000d);
        wr(rtp_pkg::OFF_CTRL, 32'h0000_0004);
        start_pin_a <= '1;
        for (int i = 0; i < 8; i++)
            np(8'ha0 + seq[i]);
        rd(rtp_pkg::OFF_CTRL);
        chk(got, 32'h0000_0014);
        rd(rtp_pkg::OFF_STAT);
        chk(got[0], 1'h1);
        chk(pattern_output_port_b, '0);
        $display("repeat test done");
    endtask
    task automatic t_oneshot;
        logic [31:0] old;
        wr(rtp_pkg::OFF_CTRL, 32'h0000_0006);
        wr(rtp_pkg::OFF_MODE, 32'h0000_0003);
        rd(rtp_pkg::OFF_PTR[0]);
        old = got;
        wr(rtp_pkg::OFF_PTR[0], 32'h0000_000e);
        rd(rtp_pkg::OFF_PTR[0]);
        chk(got, old);
        // Either edge fires in one-shot; the falling one here
        start_pin_a <= '0;
        np(8'ha1);
        np(8'ha0);
        np(8'ha2);
        repeat (40) @(posedge aclk);
        chk(pattern_output_port_a, 8'ha2);
        rd(rtp_pkg::OFF_PTR[0]);
        chk(got, 32'h0000_0001);
        rd(rtp_pkg::OFF_LAT_HI[0]);
        chk(got, '0);
        rd(rtp_pkg::OFF_LAT_LO[0]);
        chk(got, 32'h0000_0003);
        wr(rtp_pkg::OFF_STAT, 32'h0000_0003);
        rd(rtp_pkg::OFF_STAT);
        chk(got, '0);
        $display("one-shot test done");
    endtask
    // Set B: internal rising trigger, five stages, slow source, masked flag
    task automatic t_timer_b;
        wr(rtp_pkg::OFF_MODE, 32'h0000_0068);
        wr(rtp_pkg::OFF_CTRL, 32'h0000_0005);
        wr(rtp_pkg::OFF_PTR[1], 32'h0000_000b);
        external_trigger_input <= '1;
        np(8'ha3, 1'b1);
        np(8'ha2, 1'b1);
        repeat (10) @(posedge aclk);
        chk(pattern_output_port_b, 8'ha2);
        np(8'ha1, 1'b1);
        rd(rtp_pkg::OFF_STAT);
        chk(got[1], 1'h0);
        wr(rtp_pkg::OFF_MODE, 32'h0000_0060);
        np(8'ha0, 1'b1);
        rd(rtp_pkg::OFF_STAT);
        chk(got[1], 1'h1);
        np(8'ha4, 1'b1);
        rd(rtp_pkg::OFF_MODE);
        chk(got, 32'h0000_0068);
        $display("timer B test done");
    endtask
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= '1;
        t_regs;
        t_repeat;
        t_oneshot;
        t_timer_b;
        report_and_stop;
    end
    initial begin
        repeat (20000) @(posedge aclk);
        failures++;
        report_and_stop;
    end
endmodule
`default_nettype wire

// ===== tb/rtp_properties.sv
// Bus handshake and read data checks of the pattern output unit
`timescale 1ns/10ps
`default_nettype none
module rtp_properties (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic rvalid,
    input wire logic rready
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_write_answer: assert property (
        awvalid && awready && wvalid && wready |=> ##1 bvalid)
        else $error("write answer late");
    a_bresp_hold: assert property (
        bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write answer dropped");
    a_rdata_hold: assert property (
        rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read answer dropped");
    a_read_answer: assert property (
        arvalid && arready |=> rvalid) else $error("read answer late");
    a_write_closed: assert property (
        bvalid |-> !awready && !wready) else $error("write not refused");
    a_read_closed: assert property (
        rvalid |-> !arready) else $error("read not refused");
    a_read_reopen: assert property (
        rvalid && rready |=> !rvalid && arready)
        else $error("read not reopened");
    a_upper_zero: assert property (
        rvalid |-> rdata[31:8] == 24'h00_0000) else $error("upper bits set");
endmodule
bind realtime_pattern_output_port rtp_properties props (.*);
`default_nettype wire

// ===== verilog/realtime_pattern_output_port.sv
// Two-timer pattern output unit with AXI4-Lite register access
//
// The register offsets and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module realtime_pattern_output_port #(
    parameter int CNT_W = 16,
    parameter int PAT_W = 8,
    parameter int PAT_D = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic external_trigger_input,
    input wire logic start_pin_a,
    input wire logic start_pin_b,
    output logic [7:0] pattern_output_port_a,
    output logic [7:0] pattern_output_port_b
);
    if (CNT_W != 16 || PAT_W != 8 || PAT_D != 8) begin : g_bad
        $error("realtime_pattern_output_port: unsupported size");
    end

    // ****************************************
    // Declarations
    // ****************************************
    logic [7:0] waddr_q;
    logic [31:0] wdata_q;
    logic wstrb0_q;
    logic wr_go;
    logic wr_en;
    logic ar_go;
    logic [31:0] rd_mux;
    logic src_slow;
    logic edge_rise;
    logic [3:0] pre;
    logic tick;
    logic [2:0] pin_s1;
    logic [2:0] pin_s2;
    logic [2:0] pin_s3;
    logic int_edge;
    logic [1:0] stop;
    logic [1:0] trig_ext;
    logic [1:0] irq_mode;
    logic [1:0] irq_flag;
    logic [1:0] wptr;
    logic [1:0] held;
    logic [1:0] trig;
    logic [1:0] uf;
    logic [1:0] os_end;
    logic [1:0] oneshot;
    logic [1:0] ptr_wr;
    rtp_pkg::mode_type mode [2];
    logic [2:0] out_ptr [2];
    logic [2:0] rw_ptr;
    logic [7:0] pat_q [2];
    logic [7:0] lo_byte [2];
    logic [7:0] hold [2];
    logic [15:0] lat0 [2];
    logic [15:0] lat1 [2];
    logic [2:0] mem_raddr [4];
    logic [7:0] mem_rdata [4];
    // Plain copies of the timer links; an instance array needs constant indices
    logic [CNT_W-1:0] cnt [2];
    logic tmr_uf [2];

    timer_link_if #(.W(CNT_W)) link [2] ();

    function automatic logic hit(input logic [7:0] a,
                                 input logic [7:0] off);
        hit = (a == off);
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        mapped = hit(a, rtp_pkg::OFF_CTRL) || hit(a, rtp_pkg::OFF_MODE)
            || hit(a, rtp_pkg::OFF_PTR[0]) || hit(a, rtp_pkg::OFF_PTR[1])
            || hit(a, rtp_pkg::OFF_PAT) || hit(a, rtp_pkg::OFF_WPTR)
            || hit(a, rtp_pkg::OFF_STAT)
            || hit(a, rtp_pkg::OFF_LAT_LO[0])
            || hit(a, rtp_pkg::OFF_LAT_LO[1])
            || hit(a, rtp_pkg::OFF_LAT_HI[0])
            || hit(a, rtp_pkg::OFF_LAT_HI[1]);
    endfunction

    // ****************************************
    // AXI4-Lite write channel
    // ****************************************
    assign wr_go = !awready && !wready && !bvalid;
    assign wr_en = wr_go && wstrb0_q && mapped(waddr_q);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready <= 1'b1;
            waddr_q <= 8'h00;
        end else if (awvalid && awready) begin
            awready <= 1'b0;
            waddr_q <= awaddr;
        end else if (bvalid && bready) begin
            awready <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wready <= 1'b1;
            wdata_q <= 32'h0000_0000;
            wstrb0_q <= 1'b0;
        end else if (wvalid && wready) begin
            wready <= 1'b0;
            wdata_q <= wdata;
            wstrb0_q <= wstrb[0];
        end else if (bvalid && bready) begin
            wready <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp <= rtp_pkg::RESP_OKAY;
        end else if (wr_go) begin
            bvalid <= 1'b1;
            bresp <= mapped(waddr_q) ? rtp_pkg::RESP_OKAY
                                     : rtp_pkg::RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // ****************************************
    // AXI4-Lite read channel
    // ****************************************
    assign ar_go = arvalid && arready;

    always_comb begin
        rd_mux = 32'h0000_0000;
        if (hit(araddr, rtp_pkg::OFF_CTRL)) begin
            rd_mux[rtp_pkg::CTRL_SRC] = src_slow;
        end else if (hit(araddr, rtp_pkg::OFF_MODE)) begin
            rd_mux[rtp_pkg::MODE_EDGE] = edge_rise;
        end else if (hit(araddr, rtp_pkg::OFF_PAT)) begin
            rd_mux[7:0] = mem_rdata[3];
        end else if (hit(araddr, rtp_pkg::OFF_WPTR)) begin
            rd_mux[1:0] = wptr;
        end else if (hit(araddr, rtp_pkg::OFF_STAT)) begin
            rd_mux[1:0] = irq_flag;
        end
        for (int i = 0; i < 2; i++) begin
            if (hit(araddr, rtp_pkg::OFF_CTRL)) begin
                rd_mux[rtp_pkg::CTRL_STOP[i]] = stop[i];
                rd_mux[rtp_pkg::CTRL_TRIG[i]] = trig_ext[i];
            end
            if (hit(araddr, rtp_pkg::OFF_MODE)) begin
                rd_mux[rtp_pkg::MODE_LSB[i] +: 2] = mode[i];
                rd_mux[rtp_pkg::MODE_IRQ[i]] = irq_mode[i];
            end
            if (hit(araddr, rtp_pkg::OFF_PTR[i])) begin
                rd_mux[2:0] = out_ptr[i];
            end
            if (hit(araddr, rtp_pkg::OFF_LAT_LO[i])) begin
                rd_mux[7:0] = held[i] ? hold[i] : cnt[i][7:0];
            end
            if (hit(araddr, rtp_pkg::OFF_LAT_HI[i])) begin
                rd_mux[7:0] = cnt[i][15:8];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= rtp_pkg::RESP_OKAY;
        end else if (ar_go) begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rdata <= rd_mux;
            rresp <= mapped(araddr) ? rtp_pkg::RESP_OKAY
                                    : rtp_pkg::RESP_SLVERR;
        end else if (rvalid && rready) begin
            arready <= 1'b1;
            rvalid <= 1'b0;
        end
    end

    // ****************************************
    // Shared configuration and count source
    // ****************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            src_slow <= 1'b0;
            edge_rise <= 1'b0;
        end else begin
            if (wr_en && hit(waddr_q, rtp_pkg::OFF_CTRL))
                src_slow <= wdata_q[rtp_pkg::CTRL_SRC];
            if (wr_en && hit(waddr_q, rtp_pkg::OFF_MODE))
                edge_rise <= wdata_q[rtp_pkg::MODE_EDGE];
        end
    end

    // Prescaler is free running; a source switch may give one short period
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pre <= 4'h0;
            tick <= 1'b0;
        end else begin
            pre <= pre + 4'h1;
            tick <= src_slow
                ? ((pre & rtp_pkg::PRE_MASK_SLOW) == rtp_pkg::PRE_MASK_SLOW)
                : ((pre & rtp_pkg::PRE_MASK_FAST)
                   == rtp_pkg::PRE_MASK_FAST);
        end
    end

    // ****************************************
    // Trigger pins: synchronise, then find edges
    // ****************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_s1 <= 3'h0;
            pin_s2 <= 3'h0;
            pin_s3 <= 3'h0;
        end else begin
            pin_s1 <= {start_pin_b, start_pin_a, external_trigger_input};
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
        end
    end

    assign int_edge = edge_rise ? (pin_s2[0] && !pin_s3[0])
                                : (!pin_s2[0] && pin_s3[0]);

    always_comb begin
        for (int i = 0; i < 2; i++) begin
            oneshot[i] = (mode[i] == rtp_pkg::MODE_ONESHOT);
            if (!trig_ext[i]) begin
                trig[i] = int_edge;
            end else if (oneshot[i]) begin
                trig[i] = pin_s2[i + 1] ^ pin_s3[i + 1];
            end else begin
                trig[i] = pin_s2[i + 1] && !pin_s3[i + 1];
            end
            uf[i] = tmr_uf[i] && !stop[i];
            os_end[i] = uf[i] && oneshot[i]
                && (out_ptr[i] == rtp_pkg::OS_LAST_PTR);
            ptr_wr[i] = wr_en && hit(waddr_q, rtp_pkg::OFF_PTR[i]);
        end
    end

    // ****************************************
    // Per-timer mode and trigger selection
    // ****************************************
    always_ff @(posedge aclk) begin
        for (int i = 0; i < 2; i++) begin
            if (!aresetn) begin
                mode[i] <= rtp_pkg::MODE_REP8;
                irq_mode[i] <= 1'b0;
                trig_ext[i] <= 1'b0;
            end else begin
                if (wr_en && hit(waddr_q, rtp_pkg::OFF_MODE)) begin
                    if (stop[i])
                        mode[i] <= rtp_pkg::mode_type'(
                            wdata_q[rtp_pkg::MODE_LSB[i] +: 2]);
                    irq_mode[i] <= wdata_q[rtp_pkg::MODE_IRQ[i]];
                end
                if (wr_en && hit(waddr_q, rtp_pkg::OFF_CTRL))
                    trig_ext[i] <= wdata_q[rtp_pkg::CTRL_TRIG[i]];
            end
        end
    end

    // Trigger wins over a stop write in the same cycle
    always_ff @(posedge aclk) begin
        for (int i = 0; i < 2; i++) begin
            if (!aresetn) begin
                stop[i] <= 1'b1;
            end else if (trig[i]) begin
                stop[i] <= 1'b0;
            end else if (os_end[i] || (wr_en
                && hit(waddr_q, rtp_pkg::OFF_CTRL)
                && wdata_q[rtp_pkg::CTRL_STOP[i]])) begin
                stop[i] <= 1'b1;
            end
        end
    end

    // ****************************************
    // Output pointers and pattern pins
    // ****************************************
    always_ff @(posedge aclk) begin
        for (int i = 0; i < 2; i++) begin
            if (!aresetn) begin
                out_ptr[i] <= rtp_pkg::PTR_ZERO;
            end else if (trig[i]) begin
                out_ptr[i] <= oneshot[i] ? rtp_pkg::PTR_ZERO
                    : rtp_pkg::dec_ptr(out_ptr[i], mode[i]);
            end else if (uf[i]) begin
                out_ptr[i] <= rtp_pkg::dec_ptr(out_ptr[i], mode[i]);
            end else if (ptr_wr[i] && wdata_q[rtp_pkg::PTR_SWITCH]
                         && !oneshot[i]) begin
                out_ptr[i] <= wdata_q[2:0];
            end
        end
    end

    always_ff @(posedge aclk) begin
        for (int i = 0; i < 2; i++) begin
            if (!aresetn) begin
                pat_q[i] <= 8'h00;
            end else if (trig[i]) begin
                pat_q[i] <= oneshot[i] ? mem_rdata[2] : mem_rdata[i];
            end else if (uf[i]) begin
                pat_q[i] <= mem_rdata[i];
            end
        end
    end

    assign pattern_output_port_a = pat_q[0];
    assign pattern_output_port_b = pat_q[1];

    // ****************************************
    // Pattern register access pointer
    // ****************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rw_ptr <= rtp_pkg::PTR_ZERO;
        end else if (ptr_wr[0] && !wdata_q[rtp_pkg::PTR_SWITCH]) begin
            rw_ptr <= wdata_q[2:0];
        end else if (ptr_wr[1] && !wdata_q[rtp_pkg::PTR_SWITCH]) begin
            rw_ptr <= wdata_q[2:0];
        end else if (wr_en && hit(waddr_q, rtp_pkg::OFF_PAT)) begin
            rw_ptr <= rtp_pkg::dec_ptr(rw_ptr, mode[0]);
        end
    end

    assign mem_raddr[0] = out_ptr[0];
    assign mem_raddr[1] = out_ptr[1];
    assign mem_raddr[2] = rtp_pkg::OS_FIRST_REG;
    assign mem_raddr[3] = rw_ptr;

    rtp_pattern_mem #(.W(PAT_W), .D(PAT_D), .NR(4)) u_mem (
        .aclk(aclk),
        .aresetn(aresetn),
        .we(wr_en && hit(waddr_q, rtp_pkg::OFF_PAT)),
        .waddr(rw_ptr),
        .wdata(wdata_q[7:0]),
        .raddr(mem_raddr),
        .rdata(mem_rdata)
    );

    // ****************************************
    // Reload latches and read hold
    // ****************************************
    always_ff @(posedge aclk) begin
        for (int i = 0; i < 2; i++) begin
            if (!aresetn) begin
                lo_byte[i] <= 8'h00;
                lat0[i] <= 16'h0000;
                lat1[i] <= 16'h0000;
                wptr[i] <= 1'b1;
            end else if (wr_en && hit(waddr_q, rtp_pkg::OFF_LAT_LO[i])) begin
                lo_byte[i] <= wdata_q[7:0];
            end else if (wr_en && hit(waddr_q, rtp_pkg::OFF_LAT_HI[i])) begin
                if (wptr[i]) lat1[i] <= {wdata_q[7:0], lo_byte[i]};
                else lat0[i] <= {wdata_q[7:0], lo_byte[i]};
                wptr[i] <= ~wptr[i];
            end else if (wr_en && hit(waddr_q, rtp_pkg::OFF_WPTR)) begin
                wptr[i] <= wdata_q[i];
            end
        end
    end

    always_ff @(posedge aclk) begin
        for (int i = 0; i < 2; i++) begin
            if (!aresetn) begin
                held[i] <= 1'b0;
                hold[i] <= 8'h00;
            end else if (ar_go && hit(araddr, rtp_pkg::OFF_LAT_HI[i])) begin
                held[i] <= 1'b1;
                hold[i] <= cnt[i][7:0];
            end else if (ar_go && hit(araddr, rtp_pkg::OFF_LAT_LO[i])) begin
                held[i] <= 1'b0;
            end
        end
    end

    // ****************************************
    // Underflow request flags, set beats clear
    // ****************************************
    always_ff @(posedge aclk) begin
        for (int i = 0; i < 2; i++) begin
            if (!aresetn) begin
                irq_flag[i] <= 1'b0;
            end else if (uf[i] && (!irq_mode[i]
                         || out_ptr[i] == rtp_pkg::PTR_ZERO)) begin
                irq_flag[i] <= 1'b1;
            end else if (wr_en && hit(waddr_q, rtp_pkg::OFF_STAT)
                         && wdata_q[i]) begin
                irq_flag[i] <= 1'b0;
            end
        end
    end

    // ****************************************
    // Timers
    // ****************************************
    for (genvar g = 0; g < 2; g++) begin : g_tmr
        assign link[g].tick = tick;
        assign link[g].start = trig[g];
        assign link[g].run = !stop[g];
        assign link[g].latch0 = lat0[g];
        assign link[g].latch1 = lat1[g];
        assign cnt[g] = link[g].count;
        assign tmr_uf[g] = link[g].underflow;
        rtp_timer #(.W(CNT_W)) u_tmr (
            .aclk(aclk),
            .aresetn(aresetn),
            .link(link[g])
        );
    end
endmodule
`default_nettype wire

// ===== verilog/rtp_pattern_mem.sv
// Pattern register bank with registered read ports
`timescale 1ns/10ps
`default_nettype none
module rtp_pattern_mem #(
    parameter int W = 8,
    parameter int D = 8,
    parameter int NR = 4,
    parameter int AW = $clog2(D)
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [W-1:0] wdata,
    input wire logic [AW-1:0] raddr [NR],
    output logic [W-1:0] rdata [NR]
);
    logic [W-1:0] mem [D];

    if (D < 2 || NR < 1 || (1 << AW) < D) begin : g_bad
        $error("rtp_pattern_mem: bad geometry");
    end

    // ****************************************
    // Storage, cleared so pins stay low until a trigger
    // ****************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int k = 0; k < D; k++) mem[k] <= '0;
        end else if (we) begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge aclk) begin
        for (int r = 0; r < NR; r++) begin
            if (!aresetn) rdata[r] <= '0;
            else rdata[r] <= mem[raddr[r]];
        end
    end
endmodule
`default_nettype wire

// ===== verilog/rtp_pkg.sv
// Constants, register map and helpers of the pattern output unit
package rtp_pkg;

    // ****************************************
    // Register byte offsets
    // ****************************************
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_MODE = 8'h04;
    localparam logic [7:0] OFF_PTR [2] = '{8'h08, 8'h0C};
    localparam logic [7:0] OFF_PAT = 8'h10;
    localparam logic [7:0] OFF_LAT_LO [2] = '{8'h14, 8'h1C};
    localparam logic [7:0] OFF_LAT_HI [2] = '{8'h18, 8'h20};
    localparam logic [7:0] OFF_WPTR = 8'h24;
    localparam logic [7:0] OFF_STAT = 8'h28;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int CTRL_SRC = 0;
    localparam int CTRL_STOP [2] = '{1, 4};
    localparam int CTRL_TRIG [2] = '{2, 5};
    localparam int MODE_LSB [2] = '{0, 2};
    localparam int MODE_IRQ [2] = '{4, 5};
    localparam int MODE_EDGE = 6;
    localparam int PTR_SWITCH = 3;

    // ****************************************
    // Modes, pointers, prescaler, responses
    // ****************************************
    typedef enum logic [1:0] {
        MODE_REP8 = 2'h0,
        MODE_REP6 = 2'h1,
        MODE_REP5 = 2'h2,
        MODE_ONESHOT = 2'h3
    } mode_type;

    localparam logic [2:0] TOP_REP8 = 3'h7;
    localparam logic [2:0] TOP_REP6 = 3'h5;
    localparam logic [2:0] TOP_REP5 = 3'h4;
    localparam logic [2:0] TOP_ONESHOT = 3'h2;
    localparam logic [2:0] PTR_ZERO = 3'h0;
    localparam logic [2:0] OS_FIRST_REG = 3'h1;
    localparam logic [2:0] OS_LAST_PTR = 3'h2;
    localparam logic [3:0] PRE_MASK_FAST = 4'h1;
    localparam logic [3:0] PRE_MASK_SLOW = 4'hF;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Highest pointer value used by a mode
    function automatic logic [2:0] top_ptr(input mode_type m);
        case (m)
            MODE_REP8: top_ptr = TOP_REP8;
            MODE_REP6: top_ptr = TOP_REP6;
            MODE_REP5: top_ptr = TOP_REP5;
            default: top_ptr = TOP_ONESHOT;
        endcase
    endfunction

    // Step down by one, wrapping inside the mode's stage range
    function automatic logic [2:0] dec_ptr(input logic [2:0] p,
                                           input mode_type m);
        dec_ptr = (p == PTR_ZERO) ? top_ptr(m) : p - 3'h1;
    endfunction

endpackage

// ===== verilog/rtp_timer.sv
// Down counter with two reload latches
`timescale 1ns/10ps
`default_nettype none
module rtp_timer #(
    parameter int W = 16
) (
    input wire logic aclk,
    input wire logic aresetn,
    timer_link_if.tmr link
);
    logic from_latch1;

    if (W < 2) begin : g_bad
        $error("rtp_timer: width too small");
    end

    // ****************************************
    // Count, reload and underflow
    // ****************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            link.count <= '0;
            link.underflow <= 1'b0;
            from_latch1 <= 1'b0;
        end else begin
            link.underflow <= 1'b0;
            if (link.start) begin
                link.count <= link.latch1;
                from_latch1 <= 1'b0;
            end else if (link.run && link.tick) begin
                if (link.count == '0) begin
                    // Reload on the pulse after zero
                    link.count <= from_latch1 ? link.latch1
                                              : link.latch0;
                    from_latch1 <= ~from_latch1;
                    link.underflow <= 1'b1;
                end else begin
                    link.count <= link.count - 1'b1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ===== verilog/timer_link_if.sv
// Link between the control logic and one reload timer
`timescale 1ns/10ps
`default_nettype none
interface timer_link_if #(parameter int W = 16);
    logic tick;
    logic start;
    logic run;
    logic underflow;
    logic [W-1:0] latch0;
    logic [W-1:0] latch1;
    logic [W-1:0] count;
    modport ctl(output tick, start, run, latch0, latch1,
                input count, underflow);
    modport tmr(input tick, start, run, latch0, latch1,
                output count, underflow);
endinterface
`default_nettype wire
